// [rtl/shp_mnem_if.sv]
// Mnemonic buffer and per-node match result between parser and matcher
interface shp_mnem_if;
  import shp_pkg::*;
  logic [7:0] ch [MNEM_MAX];
  logic [3:0] len;
  logic [NODE_COUNT-1:0] hit;
  modport parser (output ch, output len, input hit);
  modport matcher (input ch, input len, output hit);
endinterface

// [rtl/shp_mnem_match.sv]
// Compares the collected mnemonic against every long and short tree name
module shp_mnem_match
  import shp_pkg::*;
(
  shp_mnem_if.matcher mif
);

  // ****************************************
  // One comparator per tree node
  // ****************************************
  genvar n;
  generate
    for (n = 0; n < NODE_COUNT; n++)
    begin : g_node
      logic same;
      // Buffer is already upper case, so both spellings compare alike
      always_comb
      begin
        same = (mif.len != MNEM_EMPTY) && (int'(mif.len) <= NODE_LEN[n]);
        for (int k = 0; k < MNEM_MAX; k++)
        begin
          if (k < int'(mif.len) && k < NODE_LEN[n])
          begin
            if (mif.ch[k] != NODE_NAME[n][8*(NODE_LEN[n]-1-k) +: 8])
              same = 1'b0;
          end
        end
      end
      // Long form or derived short form only, nothing in between
      assign mif.hit[n] = same && (int'(mif.len) == NODE_LEN[n]
                                   || int'(mif.len) == shp_short_len(n));
    end
  endgenerate

endmodule

// [rtl/shp_parser.sv]
// Command header parser with tree tracking, completion flag and control return
// Notes on behaviour
// - After a bus-master job completes, control goes back to the stored controller.
// - Semicolons split one message into several commands.
// - Semicolon then colon returns to the root; full path required.
// - Semicolon alone keeps the branch of the previous final mnemonic.
// - Each colon inside a header descends one tree level.
// - Space ends the header; the rest is parameter data.
// - Long and short spellings select the same node.
// - Names of four characters or fewer abbreviate only to themselves.
// - Longer names with consonant fourth character abbreviate to four characters.
// - Longer names with vowel fourth character abbreviate to three characters.
// - Commands act the same with or without implied mnemonics.
// - Marker header with a parameter acts as the marker state command.
// - Sense root is implied; paths without it resolve the same.
// - Power-up and device clears put the parser at the tree root.
// - After the completion command, set event bit 0 once nothing is pending.
module shp_parser
  import shp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_end,
  output logic in_ready,
  input wire logic dev_clear,
  input wire logic no_pending_operation_flag,
  input wire logic ctl_granted_pin,
  input wire logic bus_job_done,
  output logic cmd_valid,
  output shp_node_t cmd_node,
  output logic cmd_query,
  output logic cmd_has_data,
  output logic cmd_error,
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic esr_opc,
  output logic holding_ctl,
  output logic ctl_return,
  output logic [4:0] ctl_return_addr
);

  shp_mnem_if mif ();
  shp_mnem_match u_match (.mif(mif));

  // ****************************************
  // Byte classification
  // ****************************************
  logic [7:0] up_byte;
  logic is_colon, is_semi, is_space, is_term, is_digit;
  logic accept;
  assign in_ready = 1'b1;
  assign accept = in_valid;
  // Lower case folded before storing, so the matcher sees one case
  assign up_byte = (in_byte >= CH_LOW_A && in_byte <= CH_LOW_Z)
                   ? in_byte - CH_CASE_GAP : in_byte;
  assign is_colon = in_byte == CH_COLON;
  assign is_semi = in_byte == CH_SEMI;
  assign is_space = in_byte == CH_SPACE;
  assign is_term = in_end || in_byte == CH_LF;
  assign is_digit = in_byte >= CH_DIGIT_0 && in_byte <= CH_DIGIT_9;

  // ****************************************
  // Parser state
  // ****************************************
  shp_parse_t pstate;
  shp_node_t branch;
  shp_node_t cur;
  shp_node_t hdr_node;
  logic after_semi;
  logic query;
  logic hdr_bad;
  logic [4:0] pcb_acc;
  logic [7:0] buf_ch [MNEM_MAX];
  logic [3:0] buf_len;

  always_comb
  begin
    for (int k = 0; k < MNEM_MAX; k++)
      mif.ch[k] = buf_ch[k];
    mif.len = buf_len;
  end

  // Resolve the buffered mnemonic under the current node
  logic found;
  shp_node_t found_node;
  always_comb
  begin
    found = 1'b0;
    found_node = NODE_ROOT;
    for (int i = 0; i < NODE_COUNT; i++)
    begin
      if (!found && mif.hit[i] && (NODE_PARENT[i] == cur || NODE_PARENT[i] == PARENT_ANY))
      begin
        found = 1'b1;
        found_node = 5'(i);
      end
    end
    // Second chance through the implied sense root
    for (int i = 0; i < NODE_COUNT; i++)
    begin
      if (!found && mif.hit[i] && cur == NODE_ROOT && NODE_PARENT[i] == NODE_SENSE)
      begin
        found = 1'b1;
        found_node = 5'(i);
      end
    end
  end

  // Final node of the command once the header is complete
  logic pending_mnem;
  logic final_bad;
  shp_node_t final_node;
  always_comb
  begin
    pending_mnem = buf_len != MNEM_EMPTY;
    final_node = pending_mnem ? found_node : hdr_node;
    final_bad = hdr_bad || (pending_mnem && !found);
  end

  // Marker header carrying a parameter is the implied state command
  logic ends_cmd;
  logic with_data;
  shp_node_t exec_node;
  assign ends_cmd = accept && pstate != PS_SKIP && (is_semi || is_term);
  assign with_data = pstate == PS_DATA;
  assign exec_node = (with_data && final_node == NODE_MARKER)
                     ? NODE_STATE : final_node;

  // ****************************************
  // Header walk through the tree
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pstate <= PS_HEADER;
      branch <= NODE_ROOT;
      cur <= NODE_ROOT;
      hdr_node <= NODE_ROOT;
      after_semi <= 1'b0;
      query <= 1'b0;
      hdr_bad <= 1'b0;
      buf_len <= MNEM_EMPTY;
    end
    else if (dev_clear)
    begin
      pstate <= PS_HEADER;
      branch <= NODE_ROOT;
      cur <= NODE_ROOT;
      hdr_node <= NODE_ROOT;
      after_semi <= 1'b0;
      query <= 1'b0;
      hdr_bad <= 1'b0;
      buf_len <= MNEM_EMPTY;
    end
    else if (accept)
    begin
      if (is_term)
      begin
        // Terminator ends the message; next one starts at the root
        pstate <= PS_HEADER;
        branch <= NODE_ROOT;
        cur <= NODE_ROOT;
        hdr_node <= NODE_ROOT;
        after_semi <= 1'b0;
        query <= 1'b0;
        hdr_bad <= 1'b0;
        buf_len <= MNEM_EMPTY;
      end
      else if (is_semi && pstate != PS_SKIP)
      begin
        // Common commands leave the branch where it was
        if (NODE_PARENT[exec_node] != PARENT_ANY && !final_bad)
        begin
          branch <= NODE_PARENT[exec_node];
          cur <= NODE_PARENT[exec_node];
        end
        else
          cur <= branch;
        pstate <= PS_HEADER;
        hdr_node <= NODE_ROOT;
        after_semi <= 1'b1;
        query <= 1'b0;
        hdr_bad <= 1'b0;
        buf_len <= MNEM_EMPTY;
      end
      else if (pstate == PS_HEADER)
      begin
        if (is_colon)
        begin
          if (!pending_mnem && (after_semi || hdr_node == NODE_ROOT))
          begin
            // Leading colon: absolute path from the base
            cur <= NODE_ROOT;
            branch <= NODE_ROOT;
          end
          else if (!pending_mnem)
            hdr_bad <= 1'b1; // Empty mnemonic between two colons
          else
          begin
            cur <= found_node;
            hdr_node <= found_node;
            hdr_bad <= hdr_bad || !found;
            buf_len <= MNEM_EMPTY;
          end
          after_semi <= 1'b0;
        end
        else if (is_space)
        begin
          if (pending_mnem)
          begin
            hdr_node <= found_node;
            hdr_bad <= hdr_bad || !found;
            buf_len <= MNEM_EMPTY;
            pstate <= PS_DATA;
          end
          else if (hdr_node != NODE_ROOT)
            pstate <= PS_DATA;
        end
        else if (in_byte == CH_QUERY)
          query <= 1'b1;
        else if (int'(buf_len) < MNEM_MAX)
        begin
          buf_ch[buf_len] <= up_byte;
          buf_len <= buf_len + 4'h1;
          after_semi <= 1'b0;
        end
        else
          pstate <= PS_SKIP; // Over-long mnemonic: drop until terminator
      end
    end
  end

  // ****************************************
  // Command and data outputs
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_valid <= 1'b0;
      cmd_node <= NODE_ROOT;
      cmd_query <= 1'b0;
      cmd_has_data <= 1'b0;
      cmd_error <= 1'b0;
      data_valid <= 1'b0;
      data_byte <= 8'h00;
    end
    else
    begin
      cmd_valid <= !dev_clear && ends_cmd && !final_bad
                   && (pending_mnem || hdr_node != NODE_ROOT);
      cmd_error <= !dev_clear && ((ends_cmd && final_bad)
                   || (accept && pstate == PS_HEADER && !is_term && !is_semi
                       && !is_colon && !is_space && in_byte != CH_QUERY
                       && int'(buf_len) == MNEM_MAX));
      if (ends_cmd)
      begin
        cmd_node <= exec_node;
        cmd_query <= query;
        cmd_has_data <= with_data;
      end
      // Parameter bytes pass straight through after the separator
      data_valid <= !dev_clear && accept && pstate == PS_DATA && !is_semi && !is_term;
      if (accept && pstate == PS_DATA)
        data_byte <= in_byte;
    end
  end

  // ****************************************
  // Pass-control-back address capture
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pcb_acc <= ADDR_RESET;
      ctl_return_addr <= ADDR_RESET;
    end
    else if (ends_cmd && !final_bad && exec_node == NODE_PCB && with_data)
    begin
      ctl_return_addr <= pcb_acc;
      pcb_acc <= ADDR_RESET;
    end
    else if (accept && pstate == PS_DATA && hdr_node == NODE_PCB && is_digit)
      pcb_acc <= 5'(pcb_acc * 5'd10 + 5'(in_byte - CH_DIGIT_0));
    else if (accept && pstate == PS_HEADER)
      pcb_acc <= ADDR_RESET;
  end

  // ****************************************
  // Operation complete flag
  // ****************************************
  logic opc_armed;
  logic opc_cmd, cls_cmd;
  assign opc_cmd = ends_cmd && !final_bad && exec_node == NODE_OPC && !query;
  assign cls_cmd = ends_cmd && !final_bad && exec_node == NODE_CLS;
  // Set wins over a clear that lands in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      opc_armed <= 1'b0;
      esr_opc <= 1'b0;
    end
    else
    begin
      if (opc_armed && no_pending_operation_flag)
      begin
        esr_opc <= 1'b1;
        opc_armed <= 1'b0;
      end
      else if (cls_cmd)
      begin
        esr_opc <= 1'b0;
        opc_armed <= 1'b0;
      end
      else if (opc_cmd)
        opc_armed <= 1'b1;
    end
  end

  // ****************************************
  // Temporary bus control
  // ****************************************
  logic grant_meta, grant_sync, grant_prev;
  shp_ctl_t cstate;
  // Grant arrives from a bus pin, so it is synchronised first
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      grant_meta <= 1'b0;
      grant_sync <= 1'b0;
      grant_prev <= 1'b0;
    end
    else
    begin
      grant_meta <= ctl_granted_pin;
      grant_sync <= grant_meta;
      grant_prev <= grant_sync;
    end
  end

  // Control held only until the job ends; no host prompt is awaited
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cstate <= CS_IDLE;
      ctl_return <= 1'b0;
    end
    else
    begin
      ctl_return <= 1'b0;
      case (cstate)
        CS_IDLE:
          if (grant_sync && !grant_prev)
            cstate <= CS_HELD;
        CS_HELD:
          if (bus_job_done)
          begin
            ctl_return <= 1'b1;
            cstate <= CS_IDLE;
          end
        default:
          cstate <= CS_IDLE;
      endcase
    end
  end
  assign holding_ctl = cstate == CS_HELD;

endmodule

// [rtl/shp_pkg.sv]
// Shared constants, command-tree table and types of the command header parser
package shp_pkg;

  // ****************************************
  // Character codes
  // ****************************************
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7a;
  localparam logic [7:0] CH_CASE_GAP = 8'h20;
  localparam logic [7:0] CH_DIGIT_0 = 8'h30;
  localparam logic [7:0] CH_DIGIT_9 = 8'h39;

  // ****************************************
  // Command tree
  // ****************************************
  localparam int MNEM_MAX = 12;
  localparam int NODE_COUNT = 17;
  localparam int SHORT_LIMIT = 4;
  localparam int VOWEL_SHORT = 3;
  typedef logic [4:0] shp_node_t;
  localparam shp_node_t NODE_ROOT = 5'h00;
  localparam shp_node_t NODE_SENSE = 5'h01;
  localparam shp_node_t NODE_MARKER = 5'h07;
  localparam shp_node_t NODE_STATE = 5'h08;
  localparam shp_node_t NODE_PCB = 5'h0e;
  localparam shp_node_t NODE_OPC = 5'h0f;
  localparam shp_node_t NODE_CLS = 5'h10;
  localparam shp_node_t PARENT_ANY = 5'h1f;
  localparam logic [3:0] MNEM_EMPTY = 4'h0;
  localparam logic [4:0] ADDR_RESET = 5'h00;

  // Long forms right aligned: character k sits at bits 8*(len-1-k)
  localparam logic [8*MNEM_MAX-1:0] NODE_NAME [NODE_COUNT] = '{
    "", "SENSE", "FREQUENCY", "SPAN", "FULL", "SWEEP", "MODE", "MARKER",
    "STATE", "OFFSET", "MAXIMUM", "GLOBAL", "RIGHT", "ABORT", "*PCB", "*OPC", "*CLS"};
  localparam int NODE_LEN [NODE_COUNT] = '{
    0, 5, 9, 4, 4, 5, 4, 6, 5, 6, 7, 6, 5, 5, 4, 4, 4};
  localparam shp_node_t NODE_PARENT [NODE_COUNT] = '{
    5'h1f, 5'h00, 5'h01, 5'h02, 5'h03, 5'h01, 5'h05, 5'h00,
    5'h07, 5'h07, 5'h07, 5'h0a, 5'h0a, 5'h00, 5'h1f, 5'h1f, 5'h1f};

  typedef enum {PS_HEADER, PS_DATA, PS_SKIP} shp_parse_t;
  typedef enum {CS_IDLE, CS_HELD} shp_ctl_t;

  // Short form length: whole name up to four, else three or four by vowel
  function automatic int shp_short_len(input int n);
    logic [7:0] c4;
    c4 = 8'h00;
    if (NODE_LEN[n] <= SHORT_LIMIT)
      return NODE_LEN[n];
    c4 = NODE_NAME[n][8*(NODE_LEN[n]-4) +: 8];
    if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U")
      return VOWEL_SHORT;
    return SHORT_LIMIT;
  endfunction

endpackage

// [sim/shp_host_model.sv]
// Behavioural bus controller feeding program messages and passing bus control
module shp_host_model
  import shp_pkg::*;
(
  input wire logic core_clk,
  input wire logic ctl_return,
  output logic in_valid,
  output logic [7:0] in_byte,
  output logic in_end,
  output logic ctl_granted_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    in_valid = 1'b0;
    in_byte = 8'h00;
    in_end = 1'b0;
    ctl_granted_pin = 1'b0;
  end
  // Control comes home by itself once the device hands it back
  always @(negedge core_clk)
    if (ctl_return === 1'b1)
      ctl_granted_pin = 1'b0;
  // Idle gaps toggle the byte lines so a stale value is never mistaken for data
  task automatic send(input string m);
    bit slow;
    slow = $urandom % 2;
    for (int i = 0; i < m.len(); i++)
    begin
      for (int w = 0; w < 4 && slow && $urandom % 3 == 0; w++)
      begin
        in_valid = 1'b0;
        in_byte = ~in_byte;
        @(negedge core_clk);
      end
      in_valid = 1'b1;
      in_byte = m[i];
      in_end = m[i] == CH_LF && $urandom % 2 == 1;
      @(negedge core_clk);
    end
    in_valid = 1'b0;
    in_end = 1'b0;
    in_byte = ~in_byte;
    @(negedge core_clk);
  endtask
  // Return address first, then status set-up for the completion request
  task automatic prepare(input logic [4:0] addr);
    send($sformatf("*PCB %0d\n", addr));
    send("*CLS;*ESE 1;*SRE 32\n");
  endtask
  // Caller sends the job and completion command first, with nothing else pending
  task automatic grant;
    ctl_granted_pin = 1'b1;
  endtask
endmodule

// [sim/shp_parser_asserts.sv]
// Port-level assertions for the command header parser
module shp_parser_asserts
  import shp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_end,
  input wire logic dev_clear,
  input wire logic no_pending_operation_flag,
  input wire logic ctl_granted_pin,
  input wire logic bus_job_done,
  input wire logic cmd_valid,
  input wire shp_node_t cmd_node,
  input wire logic cmd_error,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic esr_opc,
  input wire logic holding_ctl,
  input wire logic ctl_return
);
  // ****
  // Checks
  // ****
  // A separator taken on this edge; results may only follow one
  wire logic took_end = in_valid && (in_byte == CH_SEMI || in_byte == CH_LF || in_end);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_CMD_AT_SEP: assert property (cmd_valid |-> $past(took_end))
    else $error("command result without a separator");
  // Errors follow a separator, or the byte that overflows a mnemonic
  AST_ERR_AFTER_BYTE: assert property (cmd_error |-> $past(in_valid))
    else $error("command error without a byte taken");
  AST_DATA_ECHO: assert property (data_valid |->
    $past(in_valid) && data_byte == $past(in_byte))
    else $error("data byte differs from the byte taken");
  AST_RESET_ROOT: assert property ($fell(rst) |->
    cmd_node == NODE_ROOT && !cmd_valid && !holding_ctl)
    else $error("parser not at root after reset");
  AST_CLEAR_QUIET: assert property (dev_clear |=> !cmd_valid && !cmd_error && !data_valid)
    else $error("output after device clear");
  AST_OPC_NEEDS_IDLE: assert property ($rose(esr_opc) |-> $past(no_pending_operation_flag))
    else $error("completion bit set while work pending");
  // Only the clear command may drop the completion bit, in its cycle or the next
  AST_OPC_STICKY: assert property ($fell(esr_opc) |->
    (cmd_valid && cmd_node == NODE_CLS) || $past(cmd_valid && cmd_node == NODE_CLS))
    else $error("completion bit lost without clear");
  AST_RETURN_PROMPT: assert property (holding_ctl && bus_job_done |=>
    ctl_return && !holding_ctl)
    else $error("control not returned after job");
  AST_RETURN_CAUSE: assert property (ctl_return |-> $past(holding_ctl && bus_job_done))
    else $error("control returned without a job end");
  // The grant pin is synchronised, so it must have stood two samples
  AST_GRANT_SYNC: assert property ($rose(holding_ctl) |->
    $past(ctl_granted_pin) && $past(ctl_granted_pin, 2))
    else $error("control taken without a settled grant");
  cover property (cmd_valid && cmd_node == NODE_STATE);
  cover property ($rose(esr_opc));
  cover property (ctl_return);
  cover property (cmd_error);
endmodule

bind shp_parser shp_parser_asserts i_chk (
  .core_clk(core_clk), .rst(rst), .in_valid(in_valid), .in_byte(in_byte), .in_end(in_end),
  .dev_clear(dev_clear), .no_pending_operation_flag(no_pending_operation_flag),
  .ctl_granted_pin(ctl_granted_pin), .bus_job_done(bus_job_done), .cmd_valid(cmd_valid),
  .cmd_node(cmd_node), .cmd_error(cmd_error), .data_valid(data_valid),
  .data_byte(data_byte), .esr_opc(esr_opc), .holding_ctl(holding_ctl),
  .ctl_return(ctl_return)
);

// [sim/shp_parser_bench.sv]
// Randomised self-checking bench for the command header parser
module shp_parser_bench
  import shp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 32;
  localparam int E = 64;
  logic core_clk, rst, dev_clear, no_pending_operation_flag, bus_job_done;
  logic in_valid, in_end, in_ready, ctl_granted_pin, cmd_valid, cmd_query, cmd_has_data;
  logic cmd_error, data_valid, esr_opc, holding_ctl, ctl_return;
  logic [7:0] in_byte, data_byte;
  logic [4:0] ctl_return_addr;
  shp_node_t cmd_node;
  logic [6:0] seen [$];
  string got_data;
  int n_fail, comparisons;
  string paths [7] = '{"MARKER:STATE", "MARKER:OFFSET", "MARKER:MAXIMUM:GLOBAL",
    "MARKER:MAXIMUM:RIGHT", "ABORT", "SENSE:SWEEP:MODE", "SENSE:FREQUENCY:SPAN:FULL"};
  int nodes [7] = '{8, 9, 11, 12, 13, 6, 4};

  shp_parser i_dut (
    .core_clk(core_clk), .rst(rst), .in_valid(in_valid), .in_byte(in_byte), .in_end(in_end),
    .in_ready(in_ready), .dev_clear(dev_clear),
    .no_pending_operation_flag(no_pending_operation_flag), .ctl_granted_pin(ctl_granted_pin),
    .bus_job_done(bus_job_done), .cmd_valid(cmd_valid), .cmd_node(cmd_node),
    .cmd_query(cmd_query), .cmd_has_data(cmd_has_data), .cmd_error(cmd_error),
    .data_valid(data_valid), .data_byte(data_byte), .esr_opc(esr_opc),
    .holding_ctl(holding_ctl), .ctl_return(ctl_return), .ctl_return_addr(ctl_return_addr)
  );
  shp_host_model i_host (
    .core_clk(core_clk), .ctl_return(ctl_return), .in_valid(in_valid), .in_byte(in_byte),
    .in_end(in_end), .ctl_granted_pin(ctl_granted_pin)
  );

  // 200 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Results are registered, so they are collected where settled
  always @(negedge core_clk)
  begin
    if (cmd_error === 1'b1)
      seen.push_back(7'h40);
    else if (cmd_valid === 1'b1)
      seen.push_back({1'b0, cmd_has_data, cmd_node});
    if (data_valid === 1'b1)
      got_data = $sformatf("%s%c", got_data, data_byte);
  end
  // Cut a hang short
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end

  // ****
  // Expectations and compares
  // ****
  function automatic string short_of(input string s);
    byte c;
    if (s.len() <= 4)
      return s;
    c = s[3];
    if (c inside {"A", "E", "I", "O", "U"})
      return s.substr(0, 2);
    return s.substr(0, 3);
  endfunction
  // Random form and random letter case of one mnemonic
  function automatic string pick(input string s);
    string r;
    r = ($urandom % 2) ? short_of(s) : s;
    for (int i = 0; i < r.len(); i++)
      if ($urandom % 2)
        r[i] = r[i] | CH_CASE_GAP;
    return r;
  endfunction
  function automatic string path_pick(input string p);
    string r;
    int s;
    s = 0;
    for (int i = 0; i <= p.len(); i++)
      if (i == p.len() || p[i] == CH_COLON)
      begin
        if (s > 0)
          r = {r, ":"};
        r = {r, pick(p.substr(s, i - 1))};
        s = i + 1;
      end
    return r;
  endfunction
  task automatic cmp_ent(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t result %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic cmp_str(input string got, input string exp);
    comparisons++;
    if (got != exp)
    begin
      n_fail++;
      $display("BAD %0t data %s want %s", $time, got, exp);
    end
  endtask
  // Send one message and compare every result and the parameter bytes
  task automatic run(input string m, input string dat, input int e[$]);
    seen.delete();
    got_data = "";
    i_host.send(m);
    repeat (4) @(negedge core_clk);
    cmp_ent(7'(seen.size()), 7'(e.size()));
    foreach (e[i])
      cmp_ent((i < seen.size()) ? seen[i] : 7'h7f, 7'(e[i]));
    cmp_str(got_data, dat);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  initial
  begin
    int k;
    rst = 1'b1;
    dev_clear = 1'b0;
    no_pending_operation_flag = 1'b1;
    bus_job_done = 1'b0;
    n_fail = 0;
    comparisons = 0;
    void'($urandom(32'h17452ee5));
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    cmp_bit(cmd_node == NODE_ROOT && in_ready, 1'b1);
    run({pick("MARKER"), ":", pick("OFFSET"), " ON;:", pick("MARKER"), ":", pick("MAXIMUM"),
      ":", pick("GLOBAL"), "\n"}, "ON", '{9 + D, 11});
    run({pick("MARKER"), ":", pick("STATE"), " ON;", pick("OFFSET"), " ON;", pick("MAXIMUM"),
      ":", pick("GLOBAL"), ";", pick("RIGHT"), "\n"}, "ONON", '{8 + D, 9 + D, 11, 12});
    run({pick("MARKER"), " ON\n"}, "ON", '{8 + D});
    run({pick("SENSE"), ":", pick("FREQUENCY"), ":SPAN:FULL;:", pick("FREQUENCY"), ":",
      pick("SPAN"), ":FULL;:SWE:MODE AUTO\n"}, "AUTO", '{4, 4, 6 + D});
    run("MARKE;:FREQ:SPA;:FREQ:SPAN;:MARKER:STATE ON;:OFFSET;:MARK:MAXI:GLOB\n", "ON",
      '{E, E, 3, 8 + D, E, E});
    run({pick("MARKER"), ":", pick("STATE"), "?\n"}, "", '{8});
    cmp_bit(cmd_query, 1'b1);
    // Empty mnemonic between colons, then a mnemonic that overflows the buffer
    run("MARKER::STATE;ABCDEFGHIJKLMN\n", "", '{E, E});
    for (int n = 0; n < 14; n++)
    begin
      k = $urandom % 7;
      run({":", path_pick(paths[k]), "\n"}, "", '{nodes[k]});
    end
    // A device clear in mid-header drops the branch already walked
    i_host.send("MARKER:");
    dev_clear = 1'b1;
    @(negedge core_clk);
    dev_clear = 1'b0;
    run("OFFSET\n", "", '{E});
    // Hand control over with one job pending, then let it finish
    no_pending_operation_flag = 1'b0;
    i_host.prepare(5'h07);
    run("ABOR;*OPC\n", "", '{13, 15});
    repeat (8) @(negedge core_clk);
    cmp_bit(esr_opc, 1'b0);
    i_host.grant();
    for (int n = 0; n < 10 && holding_ctl !== 1'b1; n++)
      @(negedge core_clk);
    cmp_bit(holding_ctl, 1'b1);
    no_pending_operation_flag = 1'b1;
    bus_job_done = 1'b1;
    @(negedge core_clk);
    bus_job_done = 1'b0;
    cmp_bit(ctl_return, 1'b1);
    cmp_ent({2'b00, ctl_return_addr}, 7'h07);
    for (int n = 0; n < 10 && esr_opc !== 1'b1; n++)
      @(negedge core_clk);
    cmp_bit(esr_opc, 1'b1);
    // A job end while not holding control is ignored
    bus_job_done = 1'b1;
    @(negedge core_clk);
    bus_job_done = 1'b0;
    cmp_bit(ctl_return, 1'b0);
    run("*CLS\n", "", '{16});
    cmp_bit(esr_opc, 1'b0);
    wrap_up();
  end
endmodule
